// ---- rtl/eep_consts.svh ----
// constants of the serial eeprom front end: geometry, opcodes, status bits, timing
// assumes nothing; included by the package and by the design modules
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

// array geometry
`define EEP_ADDR_W      19
`define EEP_PAGE_BYTES  256
`define EEP_SER_BYTES   16
`define EEP_USR_BYTES   256
`define EEP_PART_W      3

// self-timed write cycle and clock rate
`define EEP_TWC_MS      5
`define EEP_REF_MHZ     200
`define EEP_TWC_CYC     (`EEP_TWC_MS * `EEP_REF_MHZ * 1000)
`define EEP_WC_W        20

// command opcodes
`define EEP_OP_WRSR     8'h01
`define EEP_OP_WRITE    8'h02
`define EEP_OP_READ     8'h03
`define EEP_OP_WRDI     8'h04
`define EEP_OP_RDSR     8'h05
`define EEP_OP_WREN     8'h06
`define EEP_OP_WRPART   8'h32
`define EEP_OP_WRSEC    8'h42
`define EEP_OP_RDSEC    8'h4B
`define EEP_OP_LOCK     8'h82
`define EEP_OP_RDID     8'h9F

// status byte bit positions
`define EEP_SR_BUSY     0
`define EEP_SR_WEL      1
`define EEP_SR_BP_LO    2
`define EEP_SR_BP_HI    3
`define EEP_SR_ECC      4
`define EEP_SR_LOCK     5
`define EEP_SR_MODE     6

// value shifted out when nothing is to be sent
`define EEP_IDLE_BYTE   8'hFF
`define EEP_ID_BYTES    5

`endif

// ---- rtl/eep_pkg.sv ----
// types of the serial eeprom front end
// assumes eep_consts.svh is on the include path
`include "eep_consts.svh"
package eep_pkg;

    // command decoder states
    typedef enum logic [2:0] {ST_OPC, ST_ADR, ST_RD, ST_WR, ST_ARG, ST_IGN} eep_st_t;

    // one ecc codeword: 32 data bits plus 6 check bits, position 0 unused
    typedef logic [38:0] eep_cw_t;

    // state of the reference-clock core
    typedef struct packed {
        eep_st_t                 st;      // decoder state
        logic [7:0]              cmd;     // opcode of this frame
        logic [1:0]              acnt;    // address bytes taken
        logic [23:0]             adr;     // address being shifted in
        logic [`EEP_ADDR_W-1:0]  ptr;     // running access pointer
        logic [2:0]              idn;     // identification byte index
        logic                    wr_ok;   // target of this write is writable
        logic [2:0]              css;     // chip select synchroniser and edge stage
        logic [2:0]              rxs;     // byte toggle synchroniser and edge stage
        logic [7:0]              tx_byte; // next byte for the link
        logic                    tx_tgl;  // flips when tx_byte is new
        logic                    wel;     // write enable latch
        logic                    busy;    // write cycle in progress
        logic [`EEP_WC_W-1:0]    wcnt;    // write cycle timer
        logic [1:0]              bp;      // legacy block protect
        logic                    mode;    // 1: partition protection
        logic [7:0]              part;    // per-partition write inhibit
        logic                    lock;    // user security area locked
        logic                    ecc;     // correction seen in last read
        logic                    sec_tgt; // pending write goes to security area
    } eep_core_t;

    // state of the link-clock side that is not framed by chip select
    typedef struct packed {
        logic [7:0]              rx_byte; // last complete byte
        logic                    rx_tgl;  // flips per complete byte
        logic [1:0]              txs;     // tx toggle synchroniser
        logic                    tx_seen; // last tx toggle taken
    } eep_lnk_t;

endpackage : eep_pkg

// ---- rtl/eep_lnk_if.sv ----
// byte hand-over between the link-clock shifter and the reference-clock core
// assumes both ends use toggle handshakes; data is stable when its toggle moves
`timescale 1ns/1ps
interface eep_lnk_if;
    logic [7:0] rx_byte;  // received byte, link domain
    logic       rx_tgl;   // flips when rx_byte is new
    logic [7:0] tx_byte;  // byte to send, core domain
    logic       tx_tgl;   // flips when tx_byte is new

    modport link (output rx_byte, output rx_tgl, input tx_byte, input tx_tgl);
    modport core (input rx_byte, input rx_tgl, output tx_byte, output tx_tgl);
endinterface : eep_lnk_if

// ---- rtl/eep_link.sv ----
// serial shifter on the host clock: takes bytes from si, shifts bytes out on so
// assumes si and hold_n change with the host clock; chip select frames the clock
`timescale 1ns/1ps
`include "eep_consts.svh"
module eep_link (
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic rst_n,
    input  wire logic si,
    input  wire logic hold_n,
    output logic      so,
    output logic      so_oe,
    eep_lnk_if.link   lnk
);
    logic [2:0]        cnt_q;   // bit within byte, restarts each frame
    logic [6:0]        sh_q;    // received bits so far
    logic [7:0]        tx_sh_q; // bits going out
    eep_pkg::eep_lnk_t q;       // unframed state
    eep_pkg::eep_lnk_t d;
    logic              last;    // this edge completes a byte

    assign last = hold_n && (cnt_q == 3'h7);

    // framed shifting; chip select high clears it, hold freezes it
    always_ff @(posedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            cnt_q   <= 3'h0;
            sh_q    <= 7'h00;
            tx_sh_q <= `EEP_IDLE_BYTE;
        end
        else if (hold_n)
        begin
            cnt_q <= cnt_q + 3'h1;
            sh_q  <= {sh_q[5:0], si};
            if (cnt_q == 3'h7)
                tx_sh_q <= (q.txs[1] != q.tx_seen) ? lnk.tx_byte : `EEP_IDLE_BYTE;
            else
                tx_sh_q <= {tx_sh_q[6:0], 1'b1};
        end
    end

    // byte hand-over toward the core and tx toggle synchroniser
    always_comb
    begin
        d = q;
        d.txs = {q.txs[0], lnk.tx_tgl};
        if (last)
        begin
            d.rx_byte = {sh_q, si};
            d.rx_tgl  = ~q.rx_tgl;
            d.tx_seen = q.txs[1];
        end
    end

    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    // output stage changes on the falling edge; released while paused
    always_ff @(negedge sck or posedge cs_n)
    begin
        if (cs_n)
        begin
            so    <= 1'b1;
            so_oe <= 1'b0;
        end
        else
        begin
            so    <= tx_sh_q[7];
            so_oe <= hold_n;
        end
    end

    assign lnk.rx_byte = q.rx_byte;
    assign lnk.rx_tgl  = q.rx_tgl;
endmodule : eep_link

// ---- rtl/eep_core.sv ----
// serial eeprom front end: command decoder, array with ecc, security area, protection
// assumes the host clock and chip select come from the host; REF_CLK is the local clock
//
// Functional notes
// - array of 524,288 bytes, linear addressing
// - writes stay inside one 256-byte page
// - self-timed write cycle, at most 5 ms
// - single byte or sequential reads
// - chip select frames; si in, so out
// - hold pauses all inputs but chip select
// - security area separate, own commands
// - 16-byte serial value, never writable
// - 256 user bytes follow serial value
// - lock makes user security bytes read-only
// - select legacy or partition protection
// - legacy protects quarter, half or all
// - each partition protected by own bit
// - correct one bit per four bytes
// - status flag shows correction in last read
// - id read: maker, device, extended info
`timescale 1ns/1ps
`include "eep_consts.svh"
module eep_core #(
    parameter int unsigned                 WC_CYCLES  = `EEP_TWC_CYC,
    parameter logic [127:0]                SERIAL_NUM = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978,
    parameter logic [7:0]                  MFR_ID     = 8'hA5,      // arbitrary value
    parameter logic [15:0]                 DEV_ID     = 16'h1234,   // arbitrary value
    parameter logic [15:0]                 EXT_INFO   = 16'h0001    // arbitrary value
) (
    input  wire logic REF_CLK,
    input  wire logic RST_N,
    input  wire logic SCK,
    input  wire logic CS_N,
    input  wire logic SI,
    input  wire logic HOLD_N,
    output logic      SO,
    output logic      SO_OE,
    output logic      BUSY,
    output logic      ECC_CORR,
    output logic      WP_MODE
);
    localparam int AW    = `EEP_ADDR_W;
    localparam int WORDS = 2 ** (AW - 2);

    eep_lnk_if lnk ();

    eep_pkg::eep_core_t q;                              // all control state
    eep_pkg::eep_core_t n;                              // its next value
    eep_pkg::eep_cw_t   mem_q [WORDS];                  // main array, one codeword per 4 bytes
    logic [7:0]         usr_q [`EEP_USR_BYTES];         // user security bytes
    logic [7:0]         buf_q [`EEP_PAGE_BYTES];        // page being written
    logic [`EEP_PAGE_BYTES-1:0] msk_q;                  // bytes loaded into buf_q

    logic           rx_ev;    // a byte arrived
    logic           cs_rise;  // frame ended
    logic [AW-1:0]  fadr;     // address being fetched
    logic [32:0]    fdec;     // corrected word and correction flag
    logic [7:0]     fbyte;    // fetched byte
    logic [7:0]     sts;      // status byte
    logic [39:0]    id_seq;   // identification bytes in order
    logic           buf_we;   // load a byte into the page buffer
    logic [7:0]     buf_idx;
    logic           buf_clr;  // forget the page buffer
    logic           commit;   // write cycle done: program the buffer

    // single-error-correcting code over 32 bits
    function automatic eep_pkg::eep_cw_t ecc_enc(input logic [31:0] dat);
        eep_pkg::eep_cw_t c;
        int               j;
        logic [5:0]       s;
        c = '0;
        j = 0;
        s = 6'h00;
        for (int p = 1; p < 39; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                c[p] = dat[j];
                j++;
            end
        end
        for (int p = 1; p < 39; p++)
            if (c[p]) s = s ^ 6'(p);
        for (int k = 0; k < 6; k++)
            c[1 << k] = s[k];
        return c;
    endfunction : ecc_enc

    // returns {corrected, data}; one wrong bit anywhere is repaired
    function automatic logic [32:0] ecc_dec(input eep_pkg::eep_cw_t cw);
        eep_pkg::eep_cw_t c;
        logic [31:0]      dat;
        logic [5:0]       s;
        int               j;
        c = cw;
        dat = 32'h0000_0000;
        s = 6'h00;
        j = 0;
        for (int p = 1; p < 39; p++)
            if (c[p]) s = s ^ 6'(p);
        if (s != 6'h00 && s < 6'd39)
            c[s] = ~c[s];
        for (int p = 1; p < 39; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                dat[j] = c[p];
                j++;
            end
        end
        return {(s != 6'h00), dat};
    endfunction : ecc_dec

    // legacy or partition protection of one main-array address
    function automatic logic is_prot(input logic [AW-1:0] a, input eep_pkg::eep_core_t r);
        if (r.mode)
            return r.part[a[AW-1 -: `EEP_PART_W]];
        case (r.bp)
            2'h1:    return (a[AW-1 -: 2] == 2'h3);
            2'h2:    return a[AW-1];
            2'h3:    return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : is_prot

    // host clock side
    eep_link u_link (
        .sck    (SCK),
        .cs_n   (CS_N),
        .rst_n  (RST_N),
        .si     (SI),
        .hold_n (HOLD_N),
        .so     (SO),
        .so_oe  (SO_OE),
        .lnk    (lnk.link)
    );

    // fetch path: address, ecc correction and area select
    always_comb
    begin
        fadr = (q.st == eep_pkg::ST_ADR) ? {q.adr[10:0], lnk.rx_byte} : q.ptr;
        fdec = ecc_dec(mem_q[fadr[AW-1:2]]);
        if (q.cmd == `EEP_OP_RDSEC)
        begin
            if (fadr < AW'(`EEP_SER_BYTES))
                fbyte = SERIAL_NUM[8 * (15 - fadr[3:0]) +: 8];
            else if (fadr < AW'(`EEP_SER_BYTES + `EEP_USR_BYTES))
                fbyte = usr_q[8'(fadr - AW'(`EEP_SER_BYTES))];
            else
                fbyte = `EEP_IDLE_BYTE;
        end
        else
            fbyte = fdec[8 * fadr[1:0] +: 8];
        sts = 8'h00;
        sts[`EEP_SR_BUSY] = q.busy;
        sts[`EEP_SR_WEL]  = q.wel;
        sts[`EEP_SR_BP_HI:`EEP_SR_BP_LO] = q.bp;
        sts[`EEP_SR_ECC]  = q.ecc;
        sts[`EEP_SR_LOCK] = q.lock;
        sts[`EEP_SR_MODE] = q.mode;
        id_seq = {MFR_ID, DEV_ID, EXT_INFO};
    end

    // command decoder, frame end actions and write timer
    always_comb
    begin
        n = q;
        buf_we  = 1'b0;
        buf_idx = q.ptr[7:0];
        buf_clr = 1'b0;
        commit  = 1'b0;
        n.css   = {q.css[1:0], CS_N};
        n.rxs   = {q.rxs[1:0], lnk.rx_tgl};
        rx_ev   = q.rxs[2] ^ q.rxs[1];
        cs_rise = q.css[1] & ~q.css[2];
        if (rx_ev)
        begin
            case (q.st)
                eep_pkg::ST_OPC:
                begin
                    n.cmd  = lnk.rx_byte;
                    n.acnt = 2'h0;
                    n.idn  = 3'h1;
                    n.st   = eep_pkg::ST_IGN;
                    if (!q.busy || lnk.rx_byte == `EEP_OP_RDSR)
                    begin
                        case (lnk.rx_byte)
                            `EEP_OP_READ, `EEP_OP_RDSEC:
                                n.st = eep_pkg::ST_ADR;
                            `EEP_OP_WRITE, `EEP_OP_WRSEC:
                            begin
                                n.st    = eep_pkg::ST_ADR;
                                buf_clr = 1'b1;
                            end
                            `EEP_OP_RDSR:
                            begin
                                n.st      = eep_pkg::ST_RD;
                                n.tx_byte = sts;
                                n.tx_tgl  = ~q.tx_tgl;
                            end
                            `EEP_OP_RDID:
                            begin
                                n.st      = eep_pkg::ST_RD;
                                n.tx_byte = id_seq[39 -: 8];
                                n.tx_tgl  = ~q.tx_tgl;
                            end
                            `EEP_OP_WRSR, `EEP_OP_WRPART:
                                n.st = eep_pkg::ST_ARG;
                            default:
                                n.st = eep_pkg::ST_IGN;
                        endcase
                    end
                end
                eep_pkg::ST_ADR:
                begin
                    n.adr  = {q.adr[15:0], lnk.rx_byte};
                    n.acnt = q.acnt + 2'h1;
                    if (q.acnt == 2'h2)
                    begin
                        n.ptr     = fadr;
                        n.sec_tgt = (q.cmd == `EEP_OP_WRSEC);
                        n.wr_ok   = (q.cmd == `EEP_OP_WRSEC)
                                  ? (fadr >= AW'(`EEP_SER_BYTES) && !q.lock
                                     && fadr < AW'(`EEP_SER_BYTES + `EEP_USR_BYTES))
                                  : !is_prot(fadr, q);
                        if (q.cmd == `EEP_OP_READ || q.cmd == `EEP_OP_RDSEC)
                        begin
                            n.st      = eep_pkg::ST_RD;
                            n.ptr     = fadr + AW'(1);
                            n.tx_byte = fbyte;
                            n.tx_tgl  = ~q.tx_tgl;
                            n.ecc     = (q.cmd == `EEP_OP_READ) ? fdec[32] : q.ecc;
                        end
                        else
                            n.st = eep_pkg::ST_WR;
                    end
                end
                eep_pkg::ST_RD:
                begin
                    n.tx_tgl = ~q.tx_tgl;
                    if (q.cmd == `EEP_OP_RDSR)
                        n.tx_byte = sts;
                    else if (q.cmd == `EEP_OP_RDID)
                    begin
                        n.tx_byte = (q.idn < 3'(`EEP_ID_BYTES))
                                  ? id_seq[39 - 8 * q.idn -: 8] : `EEP_IDLE_BYTE;
                        n.idn = (q.idn < 3'(`EEP_ID_BYTES)) ? q.idn + 3'h1 : q.idn;
                    end
                    else
                    begin
                        n.tx_byte = fbyte;
                        n.ptr     = q.ptr + AW'(1);
                        if (q.cmd == `EEP_OP_READ && fdec[32])
                            n.ecc = 1'b1;
                    end
                end
                eep_pkg::ST_WR:
                begin
                    buf_we  = 1'b1;
                    buf_idx = q.sec_tgt ? 8'(q.ptr - AW'(`EEP_SER_BYTES)) : q.ptr[7:0];
                    n.ptr   = {q.ptr[AW-1:8], q.ptr[7:0] + 8'h01};
                end
                eep_pkg::ST_ARG:
                begin
                    n.st = eep_pkg::ST_IGN;
                    if (q.wel)
                    begin
                        n.wel = 1'b0;
                        if (q.cmd == `EEP_OP_WRSR)
                        begin
                            n.bp   = lnk.rx_byte[`EEP_SR_BP_HI:`EEP_SR_BP_LO];
                            n.mode = lnk.rx_byte[`EEP_SR_MODE];
                        end
                        else
                            n.part = lnk.rx_byte;
                    end
                end
                default:
                    n.st = eep_pkg::ST_IGN;
            endcase
        end
        // frame end: latch-type commands act here, writes start their cycle
        if (cs_rise)
        begin
            if (!q.busy && n.st != eep_pkg::ST_OPC)
            begin
                if (n.cmd == `EEP_OP_WREN)
                    n.wel = 1'b1;
                else if (n.cmd == `EEP_OP_WRDI)
                    n.wel = 1'b0;
                else if (n.cmd == `EEP_OP_LOCK && q.wel)
                begin
                    n.lock = 1'b1;
                    n.wel  = 1'b0;
                end
                else if (n.st == eep_pkg::ST_WR && q.wel && n.wr_ok)
                begin
                    n.busy = 1'b1;
                    n.wcnt = '0;
                end
            end
            n.st  = eep_pkg::ST_OPC;
            n.cmd = 8'h00;
        end
        // self-timed write cycle
        if (q.busy)
        begin
            n.wcnt = q.wcnt + `EEP_WC_W'(1);
            if (q.wcnt == `EEP_WC_W'(WC_CYCLES - 1))
            begin
                commit = 1'b1;
                n.busy = 1'b0;
                n.wel  = 1'b0;
            end
        end
    end

    // control state register
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            q     <= '0;
            q.css <= 3'h7;
        end
        else
            q <= n;
    end

    // page buffer and nonvolatile storage, which reset leaves alone
    always_ff @(posedge REF_CLK)
    begin
        logic [31:0]       wd;
        logic [AW-3:0]     wi;
        if (buf_clr)
            msk_q <= '0;
        if (buf_we)
        begin
            buf_q[buf_idx] <= lnk.rx_byte;
            msk_q[buf_idx] <= 1'b1;
        end
        if (commit && q.sec_tgt)
        begin
            for (int i = 0; i < `EEP_USR_BYTES; i++)
                if (msk_q[i]) usr_q[i] <= buf_q[i];
        end
        else if (commit)
        begin
            for (int w = 0; w < `EEP_PAGE_BYTES / 4; w++)
            begin
                wi = {q.ptr[AW-1:8], 6'(w)};
                wd = 32'(ecc_dec(mem_q[wi]));                           // flag bit not kept
                for (int b = 0; b < 4; b++)
                    if (msk_q[4 * w + b]) wd[8 * b +: 8] = buf_q[4 * w + b];
                mem_q[wi] <= ecc_enc(wd);
            end
        end
    end

    assign lnk.tx_byte = q.tx_byte;
    assign lnk.tx_tgl  = q.tx_tgl;
    assign BUSY        = q.busy;
    assign ECC_CORR    = q.ecc;
    assign WP_MODE     = q.mode;
endmodule : eep_core

// ---- tb/eep_core_asserts.sv ----
// pin checks of the eeprom front end
// assumes a bind to eep_core; sees its ports only
`timescale 1ns/1ps
module eep_chk #(
    parameter int unsigned WC_CYCLES = 50
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SI,
    input wire logic HOLD_N,
    input wire logic SO,
    input wire logic SO_OE,
    input wire logic BUSY,
    input wire logic ECC_CORR,
    input wire logic WP_MODE
);
    int unsigned bc_q; // clocks of the running write cycle
    // counts busy clocks
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
            bc_q <= 0;
        else
            bc_q <= BUSY ? bc_q + 1 : 0;
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_off; CS_N [*3]; endsequence
    sequence s_idle; CS_N [*8]; endsequence
    sequence s_hold; $fell(HOLD_N) ##0 !CS_N; endsequence
    property p_pin; s_off |-> !SO_OE && SO; endproperty
    a_pin: assert property (p_pin) else $error("so driven while deselected");
    property p_hold; s_hold |-> ##[1:64] !SO_OE; endproperty
    a_hold: assert property (p_hold) else $error("so driven in pause");
    property p_tmax; BUSY |-> bc_q < WC_CYCLES; endproperty
    a_tmax: assert property (p_tmax) else $error("write cycle too long");
    property p_tlen; $fell(BUSY) |-> bc_q == WC_CYCLES; endproperty
    a_tlen: assert property (p_tlen) else $error("write cycle too short");
    property p_start; $rose(BUSY) |-> CS_N && $past(CS_N, 2); endproperty
    a_start: assert property (p_start) else $error("write began inside frame");
    property p_mode; s_idle |-> $stable(WP_MODE); endproperty
    a_mode: assert property (p_mode) else $error("mode moved while idle");
    property p_mbusy; BUSY && $past(BUSY) |-> $stable(WP_MODE); endproperty
    a_mbusy: assert property (p_mbusy) else $error("mode moved while busy");
    property p_ecc; s_idle |-> $stable(ECC_CORR); endproperty
    a_ecc: assert property (p_ecc) else $error("ecc flag moved while idle");
endmodule : eep_chk
bind eep_core eep_chk #(.WC_CYCLES(WC_CYCLES)) chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .SCK(SCK), .CS_N(CS_N), .SI(SI), .HOLD_N(HOLD_N), .SO(SO), .SO_OE(SO_OE),
    .BUSY(BUSY), .ECC_CORR(ECC_CORR), .WP_MODE(WP_MODE));

// ---- tb/eep_host.sv ----
// host model: frames bytes on the link, mode 0, msb first
// assumes the device samples si on sck rise
`timescale 1ns/1ps
module eep_host (
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    output logic      hold_n,
    input  wire logic so
);
    logic [7:0] tx [8]; // bytes to send
    logic [7:0] rx [8]; // bytes seen on so
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        #2 cs_n = 1'b1; // a true rising edge clears the framing logic
    end
    // one frame of n bytes; a pause with noise before byte h
    task automatic frame(input int n, input int h);
        cs_n <= 1'b0;
        #40;
        for (int i = 0; i < n; i++)
        begin
            if (i == h)
            begin
                hold_n <= 1'b0;
                repeat (2)
                begin
                    si <= ~si;
                    #80 sck = 1'b1;
                    #80 sck = 1'b0;
                end
                hold_n <= 1'b1;
            end
            for (int b = 7; b >= 0; b--)
            begin
                si <= tx[i][b];
                #80 sck = 1'b1;
                rx[i] = {rx[i][6:0], so};
                #80 sck = 1'b0;
            end
        end
        #40 cs_n <= 1'b1;
        si <= ~si; // released line shows no stale value
        #200;
    endtask : frame
endmodule : eep_host

// ---- tb/tb_top.sv ----
// top bench: resets the front end, then runs command frames
// assumes design, host model and bound checker compiled first
`timescale 1ns/1ps
module tb_top;
    // id and serial values are arbitrary
    localparam logic [127:0] SER = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    localparam logic [7:0]   MFR = 8'h3C;
    localparam logic [15:0]  DEV = 16'h0A0B;
    localparam logic [15:0]  EXT = 16'h00C7;
    logic ref_clk, rst_n, sck, cs_n, si, hold_n, so, so_oe, busy, ecc_corr, wp_mode;
    int   fail_count;
    int   compares;
    always #2.5 ref_clk = ~ref_clk;
    eep_host host_u (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so(so));
    eep_core #(.WC_CYCLES(1000), .SERIAL_NUM(SER), .MFR_ID(MFR), .DEV_ID(DEV), .EXT_INFO(EXT))
    dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n), .SI(si), .HOLD_N(hold_n),
        .SO(so), .SO_OE(so_oe), .BUSY(busy), .ECC_CORR(ecc_corr), .WP_MODE(wp_mode));
    // prints counts and verdict, ends the run
    task automatic end_of_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // compares seen against expected
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // sends the low n bytes of b, first byte highest
    task automatic go(input logic [63:0] b, input int n, input int h = 9);
        for (int i = 0; i < n; i++)
            host_u.tx[i] = b[8*(n-1-i) +: 8];
        host_u.frame(n, h);
    endtask : go
    // bounded wait for the write cycle to end
    task automatic idle();
        for (int k = 0; k < 3000 && busy !== 1'b0; k++)
            @(posedge ref_clk);
        chk(busy, 1'b0);
        if (busy !== 1'b0)
            end_of_test();
    endtask : idle
    // write enable, then a write frame that starts or is dropped
    task automatic wr(input logic [63:0] b, input int n, input logic ok);
        go(64'h0006, 1);
        go(b, n);
        chk(busy, ok);
        idle();
    endtask : wr
    initial
    begin
        ref_clk = 1'b0;
        rst_n = 1'b1;
        fail_count = 0;
        compares = 0;
        #1 rst_n = 1'b0; // a true falling edge reaches the link-clock state
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(wp_mode, 1'b0);
        go(64'h9F00_0000_0000_0000, 8);
        chk(host_u.rx[2], MFR);
        chk(host_u.rx[3], DEV[15:8]);
        chk(host_u.rx[4], DEV[7:0]);
        chk(host_u.rx[5], EXT[15:8]);
        chk(host_u.rx[6], EXT[7:0]);
        $display("test id ends");
        wr(64'h02F7_00FC_0102_0304, 8, 1'b1);
        wr(64'h02F7_0000_0506_0708, 8, 1'b1);
        go(64'h0006, 1);
        go(64'h0002_F700_FEAA_55C3, 7, 4);
        chk(busy, 1'b1);
        go(64'h0005_0000, 3);
        chk(host_u.rx[2], 8'h03);
        go(64'h02F7_00FE_00, 5);
        idle();
        go(64'h0003_F700_FE00_0000, 7, 5);
        chk(host_u.rx[5], 8'hAA);
        chk(host_u.rx[6], 8'h55);
        go(64'h0307_0000_0000, 6);
        chk(host_u.rx[5], 8'hC3);
        chk(ecc_corr, 1'b0);
        $display("test page ends");
        wr(64'h010C, 2, 1'b0);
        wr(64'h0002_0000_1011, 5, 1'b0);
        wr(64'h014C, 2, 1'b0);
        chk(wp_mode, 1'b1);
        wr(64'h3201, 2, 1'b0);
        wr(64'h0002_0000_1011, 5, 1'b0);
        wr(64'h0002_0100_1022, 5, 1'b1);
        $display("test protect ends");
        wr(64'h0042_0000_0577, 5, 1'b0);
        wr(64'h0042_0000_1099, 5, 1'b1);
        go(64'h4B00_0010_0000, 6);
        chk(host_u.rx[5], 8'h99);
        go(64'h4B00_0000_0000, 6);
        chk(host_u.rx[5], SER[127:120]);
        wr(64'h0082, 1, 1'b0);
        wr(64'h0042_0000_1000, 5, 1'b0);
        go(64'h0005_0000, 3);
        chk(host_u.rx[2] & 8'hFD, 8'h6C);
        $display("test security ends");
        end_of_test();
    end
endmodule : tb_top
